// *** hw/cds_top.sv ***
/*
 * camera dma scale configuration: cr burst splitter for port b,
 * synthetic last-line pulses for ports a and b, scale ratios for port a.
 * assumes an axi4-lite master, lineRefPin from the sensor (async),
 * and same-clock line control from the capture datapath.
 */
// What this block does
// - upper half of cr burst register is the main cr burst length
// - lower half of cr burst register is the final remaining burst length
// - one pixel per byte, four per word; words are chroma pixels over four
// - a tail goes out as single transfers until exactly 4, 8 or 16 words are left, which then go as one burst
// - port a counts delay field clocks from last line pulse start
// - port a holds its synthetic pulse for width field clocks
// - port b has its own delay and width fields, same meaning
// - luma horizontal ratio in upper half, vertical in lower, times 4096
// - chroma horizontal ratio in upper half, vertical in lower
`default_nettype none

module cds_top (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic [31:0]               s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [31:0]               s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      lineRefPin,
    input  wire logic [1:0]                lastLineArm,
    output logic [1:0]                     synthLineRef,
    input  wire logic                      crLineStart,
    input  wire logic [15:0]               crLinePixels,
    output logic                           crBurstValid,
    output logic [15:0]                    crBurstLen,
    input  wire logic                      crBurstReady,
    output cds_pkg::cds_ratio_t            lumaScale,
    output cds_pkg::cds_ratio_t            chromaScale,
    output logic [3:0]                     downScale
);

    ////////////////////////////////////////////////////////////////////////
    // register bus slave
    logic                      awHeld_reg;
    logic                      wHeld_reg;
    logic [31:0]               awAddr_reg;
    logic [31:0]               wData_reg;
    logic                      doWrite;
    cds_pkg::cds_burst_cfg_t   crCfg_reg;
    cds_pkg::cds_timing_t      timing_reg [2];
    logic [31:0]               status;

    assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_reg    <= 1'b0;
            awAddr_reg    <= 32'h00000000;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld_reg && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg    <= 1'b1;
                awAddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (doWrite) begin
                awHeld_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wHeld_reg    <= 1'b0;
            wData_reg    <= 32'h00000000;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !wHeld_reg && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg    <= 1'b1;
                wData_reg    <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end else if (doWrite) begin
                wHeld_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cds_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            unique case (awAddr_reg)
                cds_pkg::ADDR_B_CR_BURST, cds_pkg::ADDR_A_LAST_LINE,
                cds_pkg::ADDR_B_LAST_LINE, cds_pkg::ADDR_LUMA_RATIO,
                cds_pkg::ADDR_CHROMA_RATIO: s_axi_bresp <= cds_pkg::RESP_OKAY;
                default: s_axi_bresp <= cds_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration registers; wstrb ignored, whole word written
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crCfg_reg     <= cds_pkg::RST_B_CR_BURST;
            timing_reg[0] <= cds_pkg::RST_LAST_LINE;
            timing_reg[1] <= cds_pkg::RST_LAST_LINE;
            lumaScale     <= cds_pkg::RST_LUMA_RATIO;
            chromaScale   <= cds_pkg::RST_CHROMA_RATIO;
        end else if (doWrite) begin
            unique case (awAddr_reg)
                cds_pkg::ADDR_B_CR_BURST:   crCfg_reg     <= wData_reg;
                cds_pkg::ADDR_A_LAST_LINE:  timing_reg[0] <= wData_reg;
                cds_pkg::ADDR_B_LAST_LINE:  timing_reg[1] <= wData_reg;
                cds_pkg::ADDR_LUMA_RATIO:   lumaScale     <= wData_reg;
                cds_pkg::ADDR_CHROMA_RATIO: chromaScale   <= wData_reg;
                default: ;
            endcase
        end
    end

    // write-only registers read as zero; status shows live state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= cds_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= 32'h00000000;
                s_axi_rresp   <= cds_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    cds_pkg::ADDR_STATUS: s_axi_rdata <= status;
                    cds_pkg::ADDR_B_CR_BURST, cds_pkg::ADDR_A_LAST_LINE,
                    cds_pkg::ADDR_B_LAST_LINE, cds_pkg::ADDR_LUMA_RATIO,
                    cds_pkg::ADDR_CHROMA_RATIO: ;
                    default: s_axi_rresp <= cds_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // synthetic last-line pulse, one engine per port
    logic                       lineRefMeta_reg;
    logic                       lineRefSync_reg;
    logic                       lineRefPrev_reg;
    logic                       lineRefRise;
    cds_pkg::cds_pulse_state_t  pulseState_reg [2];
    logic [15:0]                pulseCnt_reg   [2];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineRefMeta_reg <= 1'b0;
            lineRefSync_reg <= 1'b0;
            lineRefPrev_reg <= 1'b0;
        end else begin
            lineRefMeta_reg <= lineRefPin;
            lineRefSync_reg <= lineRefMeta_reg;
            lineRefPrev_reg <= lineRefSync_reg;
        end
    end

    assign lineRefRise = lineRefSync_reg && !lineRefPrev_reg;

    for (genvar p = 0; p < 2; p++) begin : g_port
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pulseState_reg[p] <= cds_pkg::PULSE_IDLE;
                pulseCnt_reg[p]   <= 16'h0000;
                synthLineRef[p]   <= 1'b0;
            end else begin
                unique case (pulseState_reg[p])
                    cds_pkg::PULSE_IDLE: begin
                        if (lineRefRise && lastLineArm[p]) begin
                            pulseState_reg[p] <= cds_pkg::PULSE_DELAY;
                            pulseCnt_reg[p]   <= timing_reg[p].delay;
                        end
                    end
                    cds_pkg::PULSE_DELAY: begin
                        if (pulseCnt_reg[p] <= 16'h0001) begin
                            if (timing_reg[p].width != 16'h0000) begin
                                pulseState_reg[p] <= cds_pkg::PULSE_HIGH;
                                synthLineRef[p]   <= 1'b1;
                            end else begin
                                pulseState_reg[p] <= cds_pkg::PULSE_IDLE;
                            end
                            pulseCnt_reg[p] <= timing_reg[p].width;
                        end else begin
                            pulseCnt_reg[p] <= pulseCnt_reg[p] - 16'h0001;
                        end
                    end
                    cds_pkg::PULSE_HIGH: begin
                        if (pulseCnt_reg[p] <= 16'h0001) begin
                            pulseState_reg[p] <= cds_pkg::PULSE_IDLE;
                            synthLineRef[p]   <= 1'b0;
                        end else begin
                            pulseCnt_reg[p] <= pulseCnt_reg[p] - 16'h0001;
                        end
                    end
                    default: pulseState_reg[p] <= cds_pkg::PULSE_IDLE;
                endcase
            end
        end

        a_pulse_start: assert property (@(posedge clk) disable iff (!rst_n)
            pulseState_reg[p] == cds_pkg::PULSE_DELAY && pulseCnt_reg[p] <= 1
            && timing_reg[p].width != 0 |=> synthLineRef[p])
            else $error("synthetic pulse did not start after delay");
        a_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
            $rose(synthLineRef[p]) && timing_reg[p].width == 16'h0003
            && !doWrite |-> synthLineRef[p] [*3] ##1 !synthLineRef[p])
            else $error("synthetic pulse width wrong");
        c_pulse: cover property (@(posedge clk) $fell(synthLineRef[p]));
    end

    ////////////////////////////////////////////////////////////////////////
    // cr burst splitter for port b
    cds_pkg::cds_burst_state_t  burstState_reg;
    cds_pkg::cds_burst_state_t  burstState_next;
    logic [15:0]                crRemain_reg;
    logic [15:0]                crRemain_next;
    logic [15:0]                crLen_next;
    logic [15:0]                crWords;
    logic                       burstDone;

    assign crWords   = {2'b00, crLinePixels[15:cds_pkg::PIX_PER_WORD_SHIFT]};
    assign burstDone = crBurstValid && crBurstReady;
    assign crRemain_next = burstDone ? crRemain_reg - crBurstLen
                                     : crWords;

    // choose the next transfer from what is left of the line
    always_comb begin
        burstState_next = cds_pkg::BURST_IDLE;
        crLen_next      = 16'h0000;
        if (crRemain_next == 16'h0000) begin
            burstState_next = cds_pkg::BURST_IDLE;
        end else if (crCfg_reg.mainLen != 16'h0000
                     && crRemain_next > crCfg_reg.tailLen
                     && crRemain_next >= crCfg_reg.mainLen) begin
            burstState_next = cds_pkg::BURST_MAIN;
            crLen_next      = crCfg_reg.mainLen;
        end else if (crRemain_next == cds_pkg::BURST_4
                     || crRemain_next == cds_pkg::BURST_8
                     || crRemain_next == cds_pkg::BURST_16) begin
            burstState_next = cds_pkg::BURST_TAIL;
            crLen_next      = crRemain_next;
        end else begin
            burstState_next = cds_pkg::BURST_SINGLE;
            crLen_next      = cds_pkg::SINGLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            burstState_reg <= cds_pkg::BURST_IDLE;
            crRemain_reg   <= 16'h0000;
            crBurstValid   <= 1'b0;
            crBurstLen     <= 16'h0000;
        end else if (burstDone
                     || (burstState_reg == cds_pkg::BURST_IDLE
                         && crLineStart)) begin
            burstState_reg <= burstState_next;
            crRemain_reg   <= crRemain_next;
            crBurstValid   <= burstState_next != cds_pkg::BURST_IDLE;
            crBurstLen     <= crLen_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scale direction flags and status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            downScale <= 4'h0;
        end else begin
            downScale <= {chromaScale.vert  > cds_pkg::RATIO_UNITY,
                          chromaScale.horiz > cds_pkg::RATIO_UNITY,
                          lumaScale.vert    > cds_pkg::RATIO_UNITY,
                          lumaScale.horiz   > cds_pkg::RATIO_UNITY};
        end
    end

    always_comb begin
        status = 32'h00000000;
        status[cds_pkg::ST_A_DELAY] = pulseState_reg[0] == cds_pkg::PULSE_DELAY;
        status[cds_pkg::ST_A_PULSE] = pulseState_reg[0] == cds_pkg::PULSE_HIGH;
        status[cds_pkg::ST_B_DELAY] = pulseState_reg[1] == cds_pkg::PULSE_DELAY;
        status[cds_pkg::ST_B_PULSE] = pulseState_reg[1] == cds_pkg::PULSE_HIGH;
        status[cds_pkg::ST_CR_BUSY] = burstState_reg != cds_pkg::BURST_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_main_len: assert property (@(posedge clk) disable iff (!rst_n)
        burstState_reg == cds_pkg::BURST_MAIN
        |-> crBurstValid && crBurstLen == crCfg_reg.mainLen)
        else $error("main cr burst length wrong");
    a_tail_len: assert property (@(posedge clk) disable iff (!rst_n)
        burstState_reg == cds_pkg::BURST_TAIL
        |-> crBurstLen == crRemain_reg)
        else $error("tail cr burst length wrong");
    a_single_len: assert property (@(posedge clk) disable iff (!rst_n)
        burstState_reg == cds_pkg::BURST_SINGLE
        |-> crBurstLen == 16'h0001 && crRemain_reg < 16'h0010)
        else $error("single transfer length wrong");
    a_line_words: assert property (@(posedge clk) disable iff (!rst_n)
        burstState_reg == cds_pkg::BURST_IDLE && crLineStart
        |=> crRemain_reg == ($past(crLinePixels) >> 2))
        else $error("words per line not pixels over four");
    a_b_timing: assert property (@(posedge clk) disable iff (!rst_n)
        doWrite && awAddr_reg == cds_pkg::ADDR_B_LAST_LINE
        |=> timing_reg[1].delay == $past(wData_reg[31:16])
            && timing_reg[1].width == $past(wData_reg[15:0]))
        else $error("port b timing fields wrong");
    a_luma_fields: assert property (@(posedge clk) disable iff (!rst_n)
        doWrite && awAddr_reg == cds_pkg::ADDR_LUMA_RATIO
        |=> lumaScale.horiz == $past(wData_reg[31:16])
            && lumaScale.vert == $past(wData_reg[15:0]))
        else $error("luma ratio fields wrong");
    a_chroma_fields: assert property (@(posedge clk) disable iff (!rst_n)
        doWrite && awAddr_reg == cds_pkg::ADDR_CHROMA_RATIO
        |=> chromaScale.horiz == $past(wData_reg[31:16])
            && chromaScale.vert == $past(wData_reg[15:0]))
        else $error("chroma ratio fields wrong");
    a_down_flag: assert property (@(posedge clk) disable iff (!rst_n)
        lumaScale.horiz == 16'h1000 && $stable(lumaScale.horiz)
        |=> !downScale[0])
        else $error("unity ratio flagged as downscale");

    c_write_then_resp: cover property (@(posedge clk) doWrite ##1 s_axi_bvalid);
    c_main_then_tail: cover property (@(posedge clk)
        burstState_reg == cds_pkg::BURST_MAIN ##[1:40]
        burstState_reg == cds_pkg::BURST_TAIL);
    c_singles: cover property (@(posedge clk)
        burstState_reg == cds_pkg::BURST_SINGLE [*2]);

endmodule

`default_nettype wire

// *** hw/cds_pkg.sv ***
/*
 * constants, register map and carrier types for the camera dma
 * scale configuration slice.
 * assumes a 32-bit axi4-lite register bus and a 200 mhz system clock.
 */
`default_nettype none

package cds_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_B_CR_BURST   = 32'h4f00003c;
    localparam logic [31:0] ADDR_A_LAST_LINE  = 32'h4f000040;
    localparam logic [31:0] ADDR_B_LAST_LINE  = 32'h4f000044;
    localparam logic [31:0] ADDR_STATUS       = 32'h4f000048;
    localparam logic [31:0] ADDR_LUMA_RATIO   = 32'h4f00004c;
    localparam logic [31:0] ADDR_CHROMA_RATIO = 32'h4f000050;

    // reset values
    localparam logic [31:0] RST_B_CR_BURST   = 32'h00000000;
    localparam logic [31:0] RST_LAST_LINE    = 32'h1b581040;
    localparam logic [31:0] RST_LUMA_RATIO   = 32'h14001400;
    localparam logic [31:0] RST_CHROMA_RATIO = 32'h14002800;

    // field positions of every split register
    localparam int HI_MSB = 31;
    localparam int HI_LSB = 16;
    localparam int LO_MSB = 15;
    localparam int LO_LSB = 0;

    // status bit positions
    localparam int ST_A_DELAY = 0;
    localparam int ST_A_PULSE = 1;
    localparam int ST_B_DELAY = 2;
    localparam int ST_B_PULSE = 3;
    localparam int ST_CR_BUSY = 4;

    // pixels packed per 32-bit word, as a shift
    localparam int PIX_PER_WORD_SHIFT = 2;
    // burst lengths the memory master supports
    localparam logic [15:0] BURST_4  = 16'h0004;
    localparam logic [15:0] BURST_8  = 16'h0008;
    localparam logic [15:0] BURST_16 = 16'h0010;
    localparam logic [15:0] SINGLE   = 16'h0001;
    // ratio meaning unity scaling
    localparam logic [15:0] RATIO_UNITY = 16'h1000;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [15:0] horiz;
        logic [15:0] vert;
    } cds_ratio_t;

    typedef struct packed {
        logic [15:0] delay;
        logic [15:0] width;
    } cds_timing_t;

    typedef struct packed {
        logic [15:0] mainLen;
        logic [15:0] tailLen;
    } cds_burst_cfg_t;

    typedef enum logic [1:0] {
        BURST_IDLE   = 2'b00,
        BURST_MAIN   = 2'b01,
        BURST_TAIL   = 2'b10,
        BURST_SINGLE = 2'b11
    } cds_burst_state_t;

    typedef enum logic [1:0] {
        PULSE_IDLE  = 2'b00,
        PULSE_DELAY = 2'b01,
        PULSE_HIGH  = 2'b10
    } cds_pulse_state_t;

endpackage

`default_nettype wire

// *** test/cds_partner.sv ***
/*
 * far side of the cr burst port and the sensor line reference pin.
 * assumes lineGo from the bench as a one-cycle request for one line.
 */
`default_nettype none

module cds_partner (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic lineGo,
    input  wire logic crBurstValid,
    output logic      lineRefPin,
    output logic      crBurstReady
);
    timeunit 1ns;
    timeprecision 1ps;

    int         seed = 65;
    logic [3:0] hiLeft;

    // memory side stalls at random, one beat in four
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crBurstReady <= 1'b0;
        end else begin
            crBurstReady <= (($random(seed) & 3) != 0);
        end
    end

    // sensor line: high for fifteen cycles, low otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hiLeft     <= 4'h0;
            lineRefPin <= 1'b0;
        end else begin
            hiLeft     <= lineGo ? 4'hf
                                 : (hiLeft != 4'h0 ? hiLeft - 4'h1 : 4'h0);
            lineRefPin <= lineGo || (hiLeft > 1);
        end
    end
endmodule

`default_nettype wire

// *** test/cds_top_bench.sv ***
/*
 * self-checking bench for cds_top: register bus, cr bursts, pulses.
 * assumes cds_partner stands for the sensor pin and memory side.
 */
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module cds_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 0, rst_n = 0, awV = 0, wV = 0, bR = 0, arV = 0, rR = 0;
    logic lineGo = 0, crStart = 0, awR, wR, bV, arR, rV, lineRef, crV, crRdy;
    logic [31:0] awA = '0, wD = '0, arA = '0, rD, y, c;
    logic [1:0]  arm = '0, bRs, rRs, synth, e2;
    logic [15:0] crPix = '0, crLen, e16;
    logic [33:0] e34;
    logic [3:0]  down;
    cds_pkg::cds_ratio_t luma, chroma;
    int n_errors = 0, checks = 0, seed = 65;
    int run[2] = '{0, 0};
    logic [1:0] qW[$];
    logic [33:0] qR[$];
    logic [15:0] qB[$], qP[$];

    cds_top dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awA),
        .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wV), .s_axi_wready(wR),
        .s_axi_bresp(bRs), .s_axi_bvalid(bV), .s_axi_bready(bR),
        .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
        .s_axi_rdata(rD), .s_axi_rresp(rRs), .s_axi_rvalid(rV),
        .s_axi_rready(rR), .lineRefPin(lineRef), .lastLineArm(arm),
        .synthLineRef(synth), .crLineStart(crStart),
        .crLinePixels(crPix), .crBurstValid(crV), .crBurstLen(crLen),
        .crBurstReady(crRdy), .lumaScale(luma), .chromaScale(chroma),
        .downScale(down));
    cds_partner far (.clk(clk), .rst_n(rst_n), .lineGo(lineGo),
        .crBurstValid(crV), .lineRefPin(lineRef), .crBurstReady(crRdy));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
        qW.push_back(r);
        @(posedge clk);
        awA <= a;
        wD <= d;
        awV <= 1;
        wV <= 1;
        bR <= 1;
        do begin
            @(posedge clk);
            if (awR) awV <= 0;
            if (wR) wV <= 0;
        end while (awV || wV);
        while (bV !== 1) @(posedge clk);
        bR <= 0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        qR.push_back(e);
        @(posedge clk);
        arA <= a;
        arV <= 1;
        rR <= 1;
        do @(posedge clk); while (arR !== 1);
        arV <= 0;
        while (rV !== 1) @(posedge clk);
        rR <= 0;
    endtask

    task automatic cr(input logic [15:0] pix, m, t);
        int rem;
        int n;
        rem = pix >> 2;
        wr(cds_pkg::ADDR_B_CR_BURST, {m, t}, cds_pkg::RESP_OKAY);
        while (m != 0 && rem > t && rem >= m) begin
            qB.push_back(m);
            rem -= m;
        end
        if (rem == 4 || rem == 8 || rem == 16) qB.push_back(16'(rem));
        else repeat (rem) qB.push_back(cds_pkg::SINGLE);
        @(posedge clk);
        crPix <= pix;
        crStart <= 1;
        @(posedge clk);
        crStart <= 0;
        n = 0;
        while (qB.size() != 0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
        `CHK("bursts left", 0, qB.size())
        $display("test cr %0d/%0d/%0d done", pix, m, t);
    endtask

    task automatic pl(input int p, input logic [15:0] d, w, input bit doWr);
        int n;
        if (doWr) wr(p ? cds_pkg::ADDR_B_LAST_LINE : cds_pkg::ADDR_A_LAST_LINE,
            {d, w}, cds_pkg::RESP_OKAY);
        qP.push_back(w);
        @(posedge clk);
        arm[p] <= 1;
        lineGo <= 1;
        @(posedge clk);
        lineGo <= 0;
        n = 1;
        while (synth[p] !== 1 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        `CHK("delay", 1'b1, n >= d && n <= d + 6)
        arm[p] <= 0;
        // long pulses: status must show the pulse of this port alone
        if (w > 16'h0010) rd(cds_pkg::ADDR_STATUS, {cds_pkg::RESP_OKAY,
            32'h1 << (p ? cds_pkg::ST_B_PULSE : cds_pkg::ST_A_PULSE)});
        repeat (w + 30) @(posedge clk);
        $display("test pulse port %0d done", p);
    endtask

    // results are matched against the oldest expectation as they appear
    always @(posedge clk) begin
        if (bV === 1 && bR) begin
            e2 = qW.pop_front();
            `CHK("bresp", e2, bRs)
        end
        if (rV === 1 && rR) begin
            e34 = qR.pop_front();
            `CHK("read", e34, {rRs, rD})
        end
        if (crV === 1 && crRdy === 1) begin
            e16 = qB.pop_front();
            `CHK("burst len", e16, crLen)
        end
        for (int p = 0; p < 2; p++) begin
            if (synth[p] === 1) run[p]++;
            else if (run[p] > 0) begin
                e16 = qP.pop_front();
                `CHK("pulse width", e16, 16'(run[p]))
                run[p] = 0;
            end
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        `CHK("luma rst", cds_pkg::RST_LUMA_RATIO, luma)
        `CHK("chroma rst", cds_pkg::RST_CHROMA_RATIO, chroma)
        `CHK("down rst", 4'hf, down)
        rd(cds_pkg::ADDR_A_LAST_LINE, {cds_pkg::RESP_OKAY, 32'h0});
        rd(cds_pkg::ADDR_STATUS, {cds_pkg::RESP_OKAY, 32'h0});
        rd(32'h4f000100, {cds_pkg::RESP_SLVERR, 32'h0});
        wr(32'h4f000100, 32'h12345678, cds_pkg::RESP_SLVERR);
        $display("test register map done");
        pl(0, 16'h1b58, 16'h1040, 0);
        pl(0, 16'h0014, 16'h0009, 1);
        pl(0, 16'h0018, 16'h0003, 1);
        pl(1, 16'h0030, 16'h0030, 1);
        cr(16'd88, 16'h0004, 16'h0002);
        cr(16'd320, 16'h0010, 16'h0010);
        cr(16'd88, 16'h0004, 16'h0004);
        cr(16'($random(seed) & 16'h01fc), 16'h0008, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            y = (i == 0) ? {16'h1000, 16'h1001} : (i == 1) ?
                {16'h0fff, 16'h3a2e} : $random(seed);
            c = $random(seed);
            wr(cds_pkg::ADDR_LUMA_RATIO, y, cds_pkg::RESP_OKAY);
            wr(cds_pkg::ADDR_CHROMA_RATIO, c, cds_pkg::RESP_OKAY);
            @(posedge clk);
            `CHK("luma", y, luma)
            `CHK("chroma", c, chroma)
            `CHK("down", {c[15:0] > 16'h1000, c[31:16] > 16'h1000,
                y[15:0] > 16'h1000, y[31:16] > 16'h1000}, down)
        end
        $display("test scale done");
        end_sim();
    end
endmodule

`default_nettype wire
